// ==== hdl/ocd_pkg.sv ====
package ocd_pkg;

    // ----------------------------------------------------------------
    // clock rates and oscillator model
    // ----------------------------------------------------------------
    localparam longint SYS_CLK_HZ  = 125_000_000;
    localparam longint OSC_NOM_HZ  = 12_000_000;
    localparam int     OSC_ACC_W   = 16;
    // phase step for half periods of the oscillator (two per cycle)
    localparam logic [OSC_ACC_W-1:0] OSC_HALF_STEP =
        OSC_ACC_W'(((2 * OSC_NOM_HZ) << OSC_ACC_W) / SYS_CLK_HZ);

    // ----------------------------------------------------------------
    // configuration clock rates, as oscillator half periods per toggle
    // ----------------------------------------------------------------
    localparam longint CFGCLK_1M_HZ  = 1_000_000;
    localparam longint CFGCLK_6M_HZ  = 6_000_000;
    localparam longint CFGCLK_12M_HZ = 12_000_000;
    localparam int     CFGCLK_CNT_W  = 4;
    localparam logic [CFGCLK_CNT_W-1:0] CFGCLK_HALF_1M =
        CFGCLK_CNT_W'(OSC_NOM_HZ / CFGCLK_1M_HZ);
    localparam logic [CFGCLK_CNT_W-1:0] CFGCLK_HALF_6M =
        CFGCLK_CNT_W'(OSC_NOM_HZ / CFGCLK_6M_HZ);
    localparam logic [CFGCLK_CNT_W-1:0] CFGCLK_HALF_12M =
        CFGCLK_CNT_W'(OSC_NOM_HZ / CFGCLK_12M_HZ);

    typedef enum logic [1:0] {
        OCD_CFGCLK_1M,
        OCD_CFGCLK_6M,
        OCD_CFGCLK_12M
    } ocd_cfgclk_sel_t;

    // ----------------------------------------------------------------
    // divider layout
    // ----------------------------------------------------------------
    localparam int DIV_W     = 16;
    localparam int SEL1_W    = 2;
    localparam int SEL2_W    = 3;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RATIO1 = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_RATIO2 = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;

    localparam int CTRL_SRC_USER_BIT = 0;
    localparam int CTRL_CFGCLK_LSB   = 1;
    localparam int CTRL_MASTER_BIT   = 3;

    localparam int STAT_POR_DONE_BIT = 0;
    localparam int STAT_CLEARING_BIT = 1;
    localparam int STAT_OUT1_BIT     = 2;
    localparam int STAT_OUT2_BIT     = 3;
    localparam int STAT_CFGCLK_BIT   = 4;

    localparam logic                RST_SRC_USER   = 1'b0;
    localparam ocd_cfgclk_sel_t     RST_CFGCLK_SEL = OCD_CFGCLK_1M;
    localparam logic                RST_MASTER     = 1'b0;
    localparam logic [SEL1_W-1:0]   RST_SEL1       = 2'h0;
    localparam logic [SEL2_W-1:0]   RST_SEL2       = 3'h0;

    // ----------------------------------------------------------------
    // start-up sequence lengths in oscillator cycles
    // ----------------------------------------------------------------
    localparam int SEQ_CNT_W       = 16;
    localparam int POR_TICKS_DEF   = 1024;
    localparam int CLEAR_TICKS_DEF = 256;

endpackage

// ==== hdl/ocd_div_if.sv ====
`timescale 1ns/10ps
interface ocd_div_if;
    import ocd_pkg::*;
    logic              src_tick;
    logic [SEL1_W-1:0] sel1;
    logic [SEL2_W-1:0] sel2;
    logic              out1;
    logic              out2;
    logic [DIV_W-1:0]  count;

    modport ctrl (output src_tick, output sel1, output sel2,
                  input out1, input out2, input count);
    modport div  (input src_tick, input sel1, input sel2,
                  output out1, output out2, output count);
endinterface

// ==== hdl/ocd_divider.sv ====
`timescale 1ns/10ps
module ocd_divider
    import ocd_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic rst_b_in,
    ocd_div_if.div    dv
);

    logic [DIV_W-1:0] ctr_q;
    logic [DIV_W-1:0] ctr_d;
    logic             out1_q;
    logic             out2_q;
    logic [SEL2_W:0]  stage2;

    // ----------------------------------------------------------------
    // free-running synchronous count on the source tick
    // ----------------------------------------------------------------
    always_comb
    begin
        ctr_d = dv.src_tick ? ctr_q + 1'b1 : ctr_q;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
            ctr_q <= '0;
        else
            ctr_q <= ctr_d;
    end

    // above 128 the second ratio steps by eight, so two stages (7 and 8) are skipped
    always_comb
    begin
        stage2 = {dv.sel2, dv.sel2[SEL2_W-1]};
    end

    // stage k is a square wave at source / 2^(k+1)
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            out1_q <= 1'b0;
            out2_q <= 1'b0;
        end
        else
        begin
            out1_q <= ctr_d[{dv.sel1, 1'b1}];
            out2_q <= ctr_d[stage2];
        end
    end

    assign dv.out1  = out1_q;
    assign dv.out2  = out2_q;
    assign dv.count = ctr_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    a_ctr_advance: assert property (
        dv.src_tick |=> ctr_q == $past(ctr_q) + 16'h0001)
        else $error("divider count did not advance on tick");
    a_ctr_hold: assert property (
        !dv.src_tick |=> $stable(ctr_q))
        else $error("divider count moved without tick");
    a_out1_stage: assert property (
        ##1 out1_q == ctr_q[{$past(dv.sel1), 1'b1}])
        else $error("first output not on selected stage");
    a_out2_stage: assert property (
        ##1 out2_q == ctr_q[2 * $past(dv.sel2) + ($past(dv.sel2) > 3'h3)])
        else $error("second output not on selected stage");

endmodule // ocd_divider

// ==== hdl/osc_clock_divider.sv ====
`timescale 1ns/10ps
module osc_clock_divider
    import ocd_pkg::*;
#(
    parameter int POR_TICKS   = POR_TICKS_DEF,
    parameter int CLEAR_TICKS = CLEAR_TICKS_DEF
)
(
    input  wire logic              clk_sys_in,
    input  wire logic              rst_b_in,
    input  wire logic              user_clk_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [DATA_W-1:0] reg_rdata_out,
    output logic                   first_divided_output_out,
    output logic                   second_divided_output_out,
    output logic                   configuration_clock_out,
    output logic                   por_done_out,
    output logic                   mem_clear_out
);

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic              src_user_q;
    ocd_cfgclk_sel_t   cfgclk_sel_q;
    logic              master_q;
    logic [SEL1_W-1:0] sel1_q;
    logic [SEL2_W-1:0] sel2_q;
    logic [DATA_W-1:0] rdata_q;

    // ----------------------------------------------------------------
    // oscillator, source and start-up state
    // ----------------------------------------------------------------
    logic [OSC_ACC_W-1:0] osc_acc_q;
    logic                 osc_half;
    logic                 osc_lvl_q;
    logic                 osc_rise;
    logic                 user_q;
    logic                 user_rise;
    logic                 src_tick;
    logic [CFGCLK_CNT_W-1:0] cfgclk_cnt_q;
    logic [CFGCLK_CNT_W-1:0] cfgclk_half;
    logic                 cfgclk_q;

    typedef enum {ST_TIMEOUT, ST_CLEAR, ST_DONE} ocd_seq_t;
    ocd_seq_t             seq_q;
    logic [SEQ_CNT_W-1:0] seq_cnt_q;

    ocd_div_if div_bus ();

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // ratio registers sit at index 1 and 2 so the index names the output
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            src_user_q <= RST_SRC_USER;
            cfgclk_sel_q <= RST_CFGCLK_SEL;
            master_q   <= RST_MASTER;
            sel1_q     <= RST_SEL1;
            sel2_q     <= RST_SEL2;
        end
        else if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                ADDR_CTRL:
                begin
                    src_user_q <= reg_wdata_in[CTRL_SRC_USER_BIT];
                    // code 3 is not a rate; fall back to the default
                    if (reg_wdata_in[CTRL_CFGCLK_LSB +: 2] == 2'h3)
                        cfgclk_sel_q <= OCD_CFGCLK_1M;
                    else
                        cfgclk_sel_q <= ocd_cfgclk_sel_t'(
                            reg_wdata_in[CTRL_CFGCLK_LSB +: 2]);
                    master_q <= reg_wdata_in[CTRL_MASTER_BIT];
                end
                ADDR_RATIO1: sel1_q <= reg_wdata_in[SEL1_W-1:0];
                ADDR_RATIO2: sel2_q <= reg_wdata_in[SEL2_W-1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    // data stand for exactly one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
            rdata_q <= '0;
        else if (reg_rd_in)
        begin
            rdata_q <= '0;
            unique case (reg_addr_in)
                ADDR_CTRL:
                begin
                    rdata_q[CTRL_SRC_USER_BIT]     <= src_user_q;
                    rdata_q[CTRL_CFGCLK_LSB +: 2]  <= cfgclk_sel_q;
                    rdata_q[CTRL_MASTER_BIT]       <= master_q;
                end
                ADDR_RATIO1: rdata_q[SEL1_W-1:0] <= sel1_q;
                ADDR_RATIO2: rdata_q[SEL2_W-1:0] <= sel2_q;
                ADDR_STATUS:
                begin
                    rdata_q[STAT_POR_DONE_BIT] <= (seq_q == ST_DONE);
                    rdata_q[STAT_CLEARING_BIT] <= (seq_q == ST_CLEAR);
                    rdata_q[STAT_OUT1_BIT]     <= div_bus.out1;
                    rdata_q[STAT_OUT2_BIT]     <= div_bus.out2;
                    rdata_q[STAT_CFGCLK_BIT]   <= cfgclk_q;
                end
                default: ;
            endcase
        end
        else
            rdata_q <= '0;
    end

    // ----------------------------------------------------------------
    // internal oscillator
    // ----------------------------------------------------------------
    // phase accumulator; jitter of one system cycle is accepted
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
            osc_acc_q <= '0;
        else
            osc_acc_q <= osc_acc_q + OSC_HALF_STEP;
    end

    // carry out of the accumulator marks each oscillator half period
    assign osc_half = (osc_acc_q + OSC_HALF_STEP) < osc_acc_q;
    assign osc_rise = osc_half && !osc_lvl_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
            osc_lvl_q <= 1'b0;
        else if (osc_half)
            osc_lvl_q <= !osc_lvl_q;
    end

    // ----------------------------------------------------------------
    // source selection
    // ----------------------------------------------------------------
    // user clock is sampled on the system clock, so it must stay
    // well below half the system rate
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
            user_q <= 1'b0;
        else
            user_q <= user_clk_in;
    end

    assign user_rise = user_clk_in && !user_q;
    assign src_tick  = src_user_q ? user_rise : osc_rise;

    assign div_bus.src_tick = src_tick;
    assign div_bus.sel1     = sel1_q;
    assign div_bus.sel2     = sel2_q;

    ocd_divider u_divider (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .dv         (div_bus.div)
    );

    // ----------------------------------------------------------------
    // configuration clock
    // ----------------------------------------------------------------
    always_comb
    begin
        unique case (cfgclk_sel_q)
            OCD_CFGCLK_6M:  cfgclk_half = CFGCLK_HALF_6M;
            OCD_CFGCLK_12M: cfgclk_half = CFGCLK_HALF_12M;
            default:        cfgclk_half = CFGCLK_HALF_1M;
        endcase
    end

    // only driven in master mode and always from the oscillator
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in || !master_q)
        begin
            cfgclk_cnt_q <= '0;
            cfgclk_q     <= 1'b0;
        end
        else if (osc_half)
        begin
            if (cfgclk_cnt_q >= cfgclk_half - 1'b1)
            begin
                cfgclk_cnt_q <= '0;
                cfgclk_q     <= !cfgclk_q;
            end
            else
                cfgclk_cnt_q <= cfgclk_cnt_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // power-on time-out and memory clear sequence
    // ----------------------------------------------------------------
    // always counted in oscillator cycles, whatever the divider source
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            seq_q     <= ST_TIMEOUT;
            seq_cnt_q <= '0;
        end
        else if (osc_rise)
        begin
            unique case (seq_q)
                ST_TIMEOUT:
                    if (seq_cnt_q == SEQ_CNT_W'(POR_TICKS - 1))
                    begin
                        seq_q     <= ST_CLEAR;
                        seq_cnt_q <= '0;
                    end
                    else
                        seq_cnt_q <= seq_cnt_q + 1'b1;
                ST_CLEAR:
                    if (seq_cnt_q == SEQ_CNT_W'(CLEAR_TICKS - 1))
                    begin
                        seq_q     <= ST_DONE;
                        seq_cnt_q <= '0;
                    end
                    else
                        seq_cnt_q <= seq_cnt_q + 1'b1;
                ST_DONE: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata_out             = rdata_q;
    assign first_divided_output_out  = div_bus.out1;
    assign second_divided_output_out = div_bus.out2;
    assign configuration_clock_out   = cfgclk_q;

    // registered copies keep the status pins glitch free
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            por_done_out  <= 1'b0;
            mem_clear_out <= 1'b0;
        end
        else
        begin
            por_done_out  <= (seq_q == ST_DONE);
            mem_clear_out <= (seq_q == ST_CLEAR);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    a_osc_tick_gap: assert property (
        osc_half |=> !osc_half ##1 !osc_half)
        else $error("oscillator half ticks too close");
    a_src_user_sel: assert property (
        src_user_q && user_clk_in && !user_q |-> src_tick)
        else $error("user clock edge not passed to divider");
    a_src_int_sel: assert property (
        !src_user_q |-> (src_tick == osc_rise))
        else $error("internal oscillator not the divider source");
    a_ratio_index: assert property (
        reg_wr_in && reg_addr_in == ADDR_RATIO1
        |=> sel1_q == $past(reg_wdata_in[SEL1_W-1:0]))
        else $error("ratio index 1 not stored");
    a_cfgclk_slave_low: assert property (
        !master_q |=> !cfgclk_q)
        else $error("configuration clock active outside master mode");
    a_cfgclk_12m_rate: assert property (
        master_q && cfgclk_sel_q == OCD_CFGCLK_12M && $past(master_q)
        && osc_half && cfgclk_cnt_q == '0 |=> cfgclk_q != $past(cfgclk_q))
        else $error("12 MHz configuration clock missed a toggle");
    a_seq_clear_first: assert property (
        $rose(por_done_out) |-> $past(mem_clear_out))
        else $error("done without memory clear");
    a_rd_one_cycle: assert property (
        !reg_rd_in |=> rdata_q == '0)
        else $error("read data outside the answer cycle");

    c_user_source:  cover property (src_user_q && src_tick);
    c_cfgclk_6m:    cover property (master_q && cfgclk_sel_q == OCD_CFGCLK_6M
                                    && $rose(cfgclk_q));
    c_seq_done:     cover property ($rose(por_done_out));
    c_status_read:  cover property (reg_rd_in
                                    && reg_addr_in == ADDR_STATUS);

endmodule // osc_clock_divider

// ==== dv/ocd_user_logic.sv ====
`timescale 1ns/10ps
// user logic on the far side: makes the user clock, times the outputs
module ocd_user_logic
(
    input  wire logic       clk_sys_in,
    input  wire logic       rst_b_in,
    input  wire logic       user_en_in,
    input  wire logic [4:0] sig_in,
    output logic            user_clk_out,
    output int              rises_out [5],
    output int              stamp_out [5]
);
    logic [1:0] div_q;
    logic [4:0] sig_q;
    int         now_q;

    // ------------------------------------------------------------
    // user clock
    // ------------------------------------------------------------
    // four system cycles a period, well below the sampling limit;
    // stands low unless this side picked the user-clock variant
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in || !user_en_in)
            div_q <= 2'h0;
        else
            div_q <= div_q + 2'h1;
    end
    assign user_clk_out = div_q[1];

    // ------------------------------------------------------------
    // edge timing
    // ------------------------------------------------------------
    // rise count and cycle stamp of the latest rise per signal
    always_ff @(posedge clk_sys_in)
    begin
        now_q <= now_q + 1;
        sig_q <= rst_b_in ? sig_in : 5'h00;
        for (int i = 0; i < 5; i++)
            if (sig_in[i] && !sig_q[i])
            begin
                rises_out[i] <= rises_out[i] + 1;
                stamp_out[i] <= now_q;
            end
    end
endmodule // ocd_user_logic

// ==== dv/osc_clock_divider_bench.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED %0t: got %0h want %0h", $time, a, b); end end
module osc_clock_divider_bench;
    import ocd_pkg::*;
    logic              clk_sys;
    logic              rst_b;
    logic              user_clk;
    logic              user_en;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              out1;
    logic              out2;
    logic              cfg_clk;
    logic              por_done;
    logic              mem_clear;
    logic [DATA_W-1:0] q;
    logic [31:0]       rnd;
    int                rises [5];
    int                stamp [5];
    int                mdl [16];
    int                errors;
    int                cmp_count;
    int                d;
    int                t;

    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    // short start-up counts keep the run brief
    osc_clock_divider #(.POR_TICKS(4), .CLEAR_TICKS(4)) i_osc_clock_divider
    (
        .clk_sys_in                (clk_sys),
        .rst_b_in                  (rst_b),
        .user_clk_in               (user_clk),
        .reg_addr_in               (reg_addr),
        .reg_wdata_in              (reg_wdata),
        .reg_wr_in                 (reg_wr),
        .reg_rd_in                 (reg_rd),
        .reg_rdata_out             (reg_rdata),
        .first_divided_output_out  (out1),
        .second_divided_output_out (out2),
        .configuration_clock_out   (cfg_clk),
        .por_done_out              (por_done),
        .mem_clear_out             (mem_clear)
    );
    ocd_user_logic i_ocd_user_logic
    (
        .clk_sys_in   (clk_sys),
        .rst_b_in     (rst_b),
        .user_en_in   (user_en),
        .sig_in       ({mem_clear, por_done, cfg_clk, out2, out1}),
        .user_clk_out (user_clk),
        .rises_out    (rises),
        .stamp_out    (stamp)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // oscillator jitter is one system cycle at each end of a span
    function automatic logic near(input int v, input int e, input int tol);
        return (v >= e - tol) && (v <= e + tol);
    endfunction

    task automatic summarize();
        $display("errors %0d, comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // write, then mirror it in the model: a clock-rate code of 3 reads 0
    task automatic wr_reg(input int a, input int v);
        @(posedge clk_sys);
        reg_addr  <= ADDR_W'(a);
        reg_wdata <= DATA_W'(v);
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        if (a == 0)
            mdl[0] = (((v >> 1) & 3) == 3) ? (v & 9) : (v & 15);
        else if (a == 1)
            mdl[1] = v & 3;
        else if (a == 2)
            mdl[2] = v & 7;
    endtask

    task automatic rd_reg(input int a, output logic [DATA_W-1:0] r);
        @(posedge clk_sys);
        reg_addr <= ADDR_W'(a);
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 r = reg_rdata;
    endtask

    task automatic rd_chk(input int a);
        rd_reg(a, q);
        `CHK(q, DATA_W'(mdl[a]))
    endtask

    task automatic wait_rises(input int i, input int n);
        int k;
        k = 0;
        while (rises[i] < n && k < 70000)
        begin
            @(posedge clk_sys);
            #1 k++;
        end
        if (k >= 70000)
        begin
            errors++;
            summarize();
        end
    endtask

    // cycles spanned by k periods, after two rises to ride out a glitch
    task automatic span(input int i, input int k, output int v);
        int t0;
        wait_rises(i, rises[i] + 2);
        t0 = stamp[i];
        wait_rises(i, rises[i] + k);
        v = stamp[i] - t0;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_b     <= 1'b0;
        user_en   <= 1'b0;
        reg_addr  <= 4'h0;
        reg_wdata <= 8'h00;
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        rnd = 32'h80c6694c;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1 `CHK({out1, out2, cfg_clk, por_done, mem_clear}, 5'h00)
        // start-up: timed clear, then done
        wait_rises(4, 1);
        wait_rises(3, 1);
        `CHK(near(stamp[3] - stamp[4], 42, 3), 1'b1)
        @(posedge clk_sys);
        #1 `CHK(mem_clear, 1'b0)
        rd_reg(3, q);
        `CHK(q[1:0], 2'h1)
        // defaults, then random traffic incl. unmapped places
        for (int a = 0; a < 3; a++)
            rd_chk(a);
        rd_chk(9);
        repeat (8)
        begin
            rnd = lfsr_next(rnd);
            wr_reg(int'(rnd[3:0]), int'(rnd[15:8]));
            if (rnd[3:0] != 4'h3)
                rd_chk(int'(rnd[3:0]));
        end
        wr_reg(0, 6);
        rd_chk(0);
        // user clock source, every ratio on the first output, ratio codes 0 to 4 on the second
        @(posedge clk_sys);
        user_en <= 1'b1;
        wr_reg(0, 1);
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(1, s);
            span(0, 2, d);
            `CHK(d, 8 * (4 << (2 * s)))
        end
        for (int s = 0; s < 5; s++)
        begin
            wr_reg(2, s);
            span(1, 2, d);
            // past 128 the ratio steps by eight: 2, 8, 32, 128, 1024
            `CHK(d, 8 * (2 << (2 * s + (s >> 2))))
        end
        span(0, 2, d);
        `CHK(d, 8 * 256)
        // internal oscillator: 12 periods of ratio r take 125 r cycles
        @(posedge clk_sys);
        user_en <= 1'b0;
        wr_reg(0, 0);
        wr_reg(1, 0);
        wr_reg(2, 0);
        span(0, 12, d);
        `CHK(near(d, 500, 2), 1'b1)
        span(1, 12, d);
        `CHK(near(d, 250, 2), 1'b1)
        // configuration clock: f periods at f MHz span one microsecond
        for (int s = 0; s < 3; s++)
        begin
            wr_reg(0, 8 | (s << 1));
            span(2, (s == 0) ? 1 : 6 * s, d);
            `CHK(near(d, 125, 2), 1'b1)
        end
        wr_reg(0, 0);
        repeat (3) @(posedge clk_sys);
        #1 t = rises[2];
        repeat (300) @(posedge clk_sys);
        #1 `CHK(rises[2], t)
        `CHK(cfg_clk, 1'b0)
        summarize();
    end
endmodule // osc_clock_divider_bench
